// ---- bench/memory_map_decoder_properties.sv ----
// checker for the memory map decoder ports
`timescale 1ns/1ps
module memory_map_decoder_properties
    import memmap_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic is_fetch,
    input wire region_s sel,
    input wire attr_s attr,
    input wire logic [15:0] local_addr,
    input wire logic [4:0] vector_index,
    input wire logic [7:0] memory_size_select,
    input wire logic [7:0] expansion_ram_size_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [1:0] n_q;
    logic ok;
    // settle count covering the synchronised reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) n_q <= 2'd0;
        else if (n_q != 2'd3) n_q <= n_q + 2'd1;
    end
    assign ok = n_q == 2'd3;
    property p_reset;
        $rose(rstn) |-> memory_size_select == 8'hcf && expansion_ram_size_select == 8'h0c;
    endproperty
    a_reset: assert property (p_reset) else $error("size reset value");
    property p_rom60;
        ok && memory_size_select == 8'hcf && addr <= 16'hefff |=> sel.rom;
    endproperty
    a_rom60: assert property (p_rom60) else $error("rom select missing");
    property p_rom48;
        ok && memory_size_select == 8'hcc && addr inside {[16'hc000:16'hf1ff]} |=> sel == '0;
    endproperty
    a_rom48: assert property (p_rom48) else $error("rom above limit");
    property p_xram;
        ok && addr inside {[16'hf200:16'hf7ff]} |=> sel.xram && local_addr == $past(addr) - 16'hf200;
    endproperty
    a_xram: assert property (p_xram) else $error("xram decode");
    property p_hs_data;
        ok && !is_fetch && addr inside {[16'hfb00:16'hfeff]} |=> sel.hsram;
    endproperty
    a_hs_data: assert property (p_hs_data) else $error("hsram decode");
    property p_hs_fetch;
        ok && is_fetch && addr inside {[16'hfb00:16'hfeff]} |=> sel == '0 && attr.fetch_fault;
    endproperty
    a_hs_fetch: assert property (p_hs_fetch) else $error("hsram fetch");
    property p_peri;
        ok && addr >= 16'hff00 |=> sel.peri && local_addr == {8'h00, $past(addr[7:0])};
    endproperty
    a_peri: assert property (p_peri) else $error("peri decode");
    property p_vec;
        ok && addr <= 16'h003f |=> attr.vector_area && vector_index == $past(addr[5:1]);
    endproperty
    a_vec: assert property (p_vec) else $error("vector decode");
    property p_onehot;
        $onehot0(sel);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two selects");
endmodule

// ---- bench/memory_map_decoder_tb.sv ----
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module memory_map_decoder_tb;
    import memmap_pkg::*;
    localparam logic [15:0] VEC = 16'h1234;
    logic clk = 0, rstn = 0, is_fetch = 0, size_wr = 0, pc_load = 0, psw_wr = 0, sp_wr = 0;
    logic lcd_segment_out_hi = 0, lcd_segment_out_lo = 0, boot_busy;
    logic [15:0] addr = 0, pc_load_val = 0, sp_wd = 0, local_addr, boot_addr, pc, sp, bank_base;
    logic [7:0] memory_size_select_wd = 0, expansion_ram_size_select_wd = 0, psw_wd = 0, rd_byte;
    logic [7:0] memory_size_select, expansion_ram_size_select, psw, ems = 8'hcf;
    logic [1:0] lcd_variant = 0, bank_sel = 0, lv = 0;
    logic [4:0] vector_index;
    logic [31:0] r;
    region_s sel;
    attr_s attr, attr_f;
    int err_count = 0, num_checks = 0, seed = 8223;
    logic [28:0] qe[$];
    time qt[$];
    logic [15:0] bnd[22] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0800, 16'h0fff,
        16'hbfff, 16'hc000, 16'hefff, 16'hf200, 16'hf7ff, 16'hfa00, 16'hfa17, 16'hfa18,
        16'hfa1f, 16'hfa20, 16'hfa27, 16'hfb00, 16'hfee0, 16'hfeff, 16'hff00, 16'hffff};
    always #4 clk = ~clk;
    memory_map_decoder i_dut(.clk(clk), .rstn(rstn), .addr(addr), .is_fetch(is_fetch),
        .lcd_variant(lcd_variant), .lcd_segment_out_hi(lcd_segment_out_hi),
        .lcd_segment_out_lo(lcd_segment_out_lo), .rd_byte(rd_byte), .size_wr(size_wr),
        .memory_size_select_wd(memory_size_select_wd),
        .expansion_ram_size_select_wd(expansion_ram_size_select_wd), .pc_load(pc_load),
        .pc_load_val(pc_load_val), .psw_wd(psw_wd), .psw_wr(psw_wr), .sp_wd(sp_wd),
        .sp_wr(sp_wr), .bank_sel(bank_sel), .sel(sel), .attr(attr), .local_addr(local_addr),
        .vector_index(vector_index), .memory_size_select(memory_size_select),
        .expansion_ram_size_select(expansion_ram_size_select), .boot_addr(boot_addr),
        .boot_busy(boot_busy), .pc(pc), .psw(psw), .sp(sp), .bank_base(bank_base));
    // flash build: display end follows the two shared pin groups
    memory_map_decoder #(.IS_FLASH(1'b1)) i_dut_f(.clk(clk), .rstn(rstn), .addr(addr),
        .is_fetch(is_fetch), .lcd_variant(lcd_variant),
        .lcd_segment_out_hi(lcd_segment_out_hi), .lcd_segment_out_lo(lcd_segment_out_lo),
        .rd_byte(rd_byte), .size_wr(size_wr), .memory_size_select_wd(memory_size_select_wd),
        .expansion_ram_size_select_wd(expansion_ram_size_select_wd), .pc_load(pc_load),
        .pc_load_val(pc_load_val), .psw_wd(psw_wd), .psw_wr(psw_wr), .sp_wd(sp_wd),
        .sp_wr(sp_wr), .bank_sel(bank_sel), .sel(), .attr(attr_f), .local_addr(),
        .vector_index(), .memory_size_select(), .expansion_ram_size_select(),
        .boot_addr(), .boot_busy(), .pc(), .psw(), .sp(), .bank_base());
    vector_rom_model #(.VEC(VEC)) i_mem(.clk(clk), .boot_addr(boot_addr),
        .boot_busy(boot_busy), .rd_byte(rd_byte));
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // expected {sel, attr, flash display, local address}
    function automatic logic [28:0] exp_of(logic [15:0] a, logic f);
        logic [4:0] s;
        logic [6:0] t;
        logic [15:0] b, e, ef;
        s = 5'h00;
        b = 16'h0000;
        e = lv == 2'd0 ? 16'hfa17 : lv == 2'd1 ? 16'hfa1f : 16'hfa27;
        ef = lv == 2'd0 ? 16'hfa17 : lv == 2'd3 ? 16'hfa27 : 16'hfa1f;
        if (a <= (ems == 8'hcc ? 16'hbfff : 16'hefff)) s = 5'h10;
        else if (a >= 16'hf200 && a <= 16'hf7ff) {s, b} = {5'h08, 16'hf200};
        else if (a >= 16'hfa00 && a <= 16'hfa27) {s, b} = {5'h04, 16'hfa00};
        else if (a >= 16'hfb00 && a <= 16'hfeff) {s, b} = {f ? 5'h00 : 5'h02, 16'hfb00};
        else if (a >= 16'hff00) {s, b} = {5'h01, 16'hff00};
        t[6] = s[4] && a <= 16'h003f;
        t[5] = s[4] && a >= 16'h0040 && a <= 16'h007f;
        t[4] = s[4] && a >= 16'h0800 && a <= 16'h0fff;
        t[3] = s[1] && a >= 16'hfee0;
        t[2] = s[2] && a <= e;
        t[1] = f && s == 5'h00 && a >= 16'hfb00;
        t[0] = s == 5'h00 && !t[1];
        return {s, t, s[2] && a <= ef, s != 0 ? a - b : 16'h0000};
    endfunction
    task automatic dec(logic [15:0] a, logic f);
        addr <= a;
        is_fetch <= f;
        qe.push_back(exp_of(a, f));
        qt.push_back($time);
        @(posedge clk);
    endtask
    task automatic wait_boot;
        for (int i = 0; i < 20 && boot_busy !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        chk(pc, VEC);
        chk(memory_size_select, 8'hcf);
        chk(expansion_ram_size_select, 8'h0c);
    endtask
    // compare each answer one cycle after its access
    always @(negedge clk) begin
        logic [28:0] e;
        logic [15:0] la;
        if (qt.size() > 0 && $time - qt[0] > 8) begin
            e = qe.pop_front();
            void'(qt.pop_front());
            la = e[28:24] != 0 ? local_addr : 16'h0000;
            chk({sel, attr, attr_f.lcd_display, la}, e);
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        wait_boot();
        chk(psw, 8'h02);
        $display("test reset done");
        for (int m = 0; m < 3; m++) begin
            if (m > 0) begin
                ems = m == 1 ? 8'hcc : 8'hcf;
                size_wr <= 1;
                memory_size_select_wd <= ems;
                expansion_ram_size_select_wd <= 8'h09;
                @(posedge clk);
                size_wr <= 0;
                @(posedge clk);
                chk({memory_size_select, expansion_ram_size_select}, {ems, 8'h09});
            end
            for (int v = 0; v < 4; v++) begin
                lv = v[1:0];
                lcd_variant <= lv;
                {lcd_segment_out_hi, lcd_segment_out_lo} <= lv;
                foreach (bnd[i]) dec(bnd[i], 1'b0);
                repeat (50) begin
                    r = $random(seed);
                    if (r[15:8] == 8'hff) r[7:0] = 8'h00;
                    dec(r[15:0], r[16]);
                end
            end
            dec(16'hf300, 1'b1);
            dec(16'hfb00, 1'b1);
            dec(16'hfeff, 1'b1);
            dec(16'h0100, 1'b1);
            repeat (2) @(posedge clk);
            $display("test decode pass %0d done", m);
        end
        for (int b = 0; b < 4; b++) begin
            bank_sel <= b[1:0];
            repeat (2) @(posedge clk);
            chk(bank_base, 16'hfef8 - 16'(8 * b));
        end
        {psw_wr, sp_wr, pc_load} <= 3'b111;
        {psw_wd, sp_wd, pc_load_val} <= {8'ha5, 16'hfe00, 16'h0800};
        @(posedge clk);
        {psw_wr, sp_wr, pc_load} <= 3'b000;
        @(posedge clk);
        chk({psw, sp}, {8'ha5, 16'hfe00});
        chk(pc, 16'h0800);
        $display("test registers done");
        rstn <= 0;
        repeat (3) @(posedge clk);
        rstn <= 1;
        wait_boot();
        $display("test second reset done");
        test_done();
    end
    // watchdog against a hung run
    initial begin
        #100000;
        err_count++;
        test_done();
    end
endmodule
bind memory_map_decoder memory_map_decoder_properties i_chk(.clk(clk), .rstn(rstn),
    .addr(addr), .is_fetch(is_fetch), .sel(sel), .attr(attr), .local_addr(local_addr),
    .vector_index(vector_index), .memory_size_select(memory_size_select),
    .expansion_ram_size_select(expansion_ram_size_select));

// ---- bench/vector_rom_model.sv ----
// stand-in memory that answers the reset vector read
`timescale 1ns/1ps
module vector_rom_model #(
    parameter logic [15:0] VEC = 16'h0000
) (
    input wire logic clk,
    input wire logic [15:0] boot_addr,
    input wire logic boot_busy,
    output logic [7:0] rd_byte
);
    logic [7:0] junk_q = 8'h5a;
    // rolling pattern while no vector read runs
    always @(posedge clk) begin
        junk_q <= ~junk_q + 8'h01;
    end
    // low byte at even address, high at odd
    assign rd_byte = !boot_busy ? junk_q : boot_addr[0] ? VEC[15:8] : VEC[7:0];
endmodule

// ---- common/memmap_pkg.sv ----
// constants and types shared by the memory map decoder
package memmap_pkg;
    localparam logic [15:0] ROM_BASE = 16'h0000;
    localparam logic [15:0] ROM48_LAST = 16'hBFFF;
    localparam logic [15:0] ROM60_LAST = 16'hEFFF;
    localparam logic [15:0] VEC_LAST = 16'h003F;
    localparam logic [15:0] SHORT_TABLE_CALL_BASE = 16'h0040;
    localparam logic [15:0] SHORT_TABLE_CALL_LAST = 16'h007F;
    localparam logic [15:0] FIXED_AREA_CALL_BASE = 16'h0800;
    localparam logic [15:0] FIXED_AREA_CALL_LAST = 16'h0FFF;
    localparam logic [15:0] XRAM_BASE = 16'hF200;
    localparam logic [15:0] XRAM_LAST = 16'hF7FF;
    localparam logic [15:0] LCD_BASE = 16'hFA00;
    localparam logic [15:0] LCD_LAST24 = 16'hFA17;
    localparam logic [15:0] LCD_LAST32 = 16'hFA1F;
    localparam logic [15:0] LCD_LAST40 = 16'hFA27;
    localparam logic [15:0] HSRAM_BASE = 16'hFB00;
    localparam logic [15:0] HSRAM_LAST = 16'hFEFF;
    localparam logic [15:0] BANK_BASE = 16'hFEE0;
    localparam logic [15:0] PERI_BASE = 16'hFF00;
    localparam logic [15:0] PERI_LAST = 16'hFFFF;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
    localparam logic [15:0] VEC_EXT_PIN0 = 16'h0006;
    localparam logic [15:0] VEC_EXT_PIN5 = 16'h0010;
    localparam logic [15:0] VEC_PERI_LAST = 16'h002E;
    localparam logic [15:0] VEC_BREAK = 16'h003E;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [7:0] MSS_RESET = 8'hCF;
    localparam logic [7:0] XSS_RESET = 8'h0C;
    localparam logic [7:0] MSS_48K = 8'hCC;
    localparam logic [7:0] MSS_60K = 8'hCF;
    localparam logic [7:0] XSS_1536 = 8'h09;
    localparam logic [1:0] LCD_SEL24 = 2'h0;
    localparam logic [1:0] LCD_SEL32 = 2'h1;
    localparam logic [1:0] LCD_SEL40 = 2'h2;
    localparam logic [2:0] BANK_IDX_W = 3'h3;

    // one-hot region selects
    typedef struct packed {
        logic rom;
        logic xram;
        logic lcd;
        logic hsram;
        logic peri;
    } region_s;

    // classification flags that travel with the selects
    typedef struct packed {
        logic vector_area;
        logic short_table_call_area;
        logic fixed_area_call_area;
        logic bank_area;
        logic lcd_display;
        logic fetch_fault;
        logic unmapped;
    } attr_s;

    typedef enum logic [1:0] {
        BOOT_LO,
        BOOT_HI,
        RUN
    } boot_e;
endpackage

// ---- core/memory_map_decoder.sv ----
// memory map decoder with size selection settings and reset vector load
//
// How it works
// (R1) one 64 KB space, 16-bit addresses, shared by fetches and data
// (R2) reset values: memory size select CFH, expansion ram select 0CH
// (R3) 48 KB part: software writes CCH and 09H
// (R4) 60 KB part: software writes CFH and 09H
// (R5) 48 KB part decodes program memory 0000H to BFFFH
// (R6) 60 KB parts decode program memory 0000H to EFFFH
// (R7) 0000H to 003FH flagged as the vector table
// (R8) vector low byte at even address, high byte at next odd
// (R9) vector slots: reset, watchdog, pins 0-5, peripherals, break
// (R10) 0040H to 007FH flagged as short table call entries
// (R11) 0800H to 0FFFH flagged as fixed area call targets
// (R12) high-speed ram 1 KB at FB00H to FEFFH
// (R13) four register banks of eight bytes at FEE0H to FEFFH
// (R14) fetch from high-speed ram is flagged as a fault, no select
// (R15) expansion ram 1,536 bytes at F200H to F7FFH
// (R16) fetch from expansion ram is allowed
// (R17) lcd ram 40 bytes at FA00H to FA27H, rest plain ram
// (R18) mask parts: display portion 24, 32 or 40 bytes by variant
// (R19) flash part: display end set by the two shared pin groups
// (R20) peripheral window FF00H to FFFFH
// (R21) software avoids unimplemented peripheral addresses
// (R22) program counter, status word, stack pointer held in the core
// (R23) after reset the program counter loads from 0000H and 0001H
// (R24) at most one region select per address
`timescale 1ns/1ps
module memory_map_decoder
    import memmap_pkg::*;
#(
    parameter logic IS_FLASH = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] addr,
    input wire logic is_fetch,
    input wire logic [1:0] lcd_variant,
    input wire logic lcd_segment_out_hi,
    input wire logic lcd_segment_out_lo,
    input wire logic [7:0] rd_byte,
    input wire logic size_wr,
    input wire logic [7:0] memory_size_select_wd,
    input wire logic [7:0] expansion_ram_size_select_wd,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_val,
    input wire logic [7:0] psw_wd,
    input wire logic psw_wr,
    input wire logic [15:0] sp_wd,
    input wire logic sp_wr,
    input wire logic [1:0] bank_sel,
    output region_s sel,
    output attr_s attr,
    output logic [15:0] local_addr,
    output logic [4:0] vector_index,
    output logic [7:0] memory_size_select,
    output logic [7:0] expansion_ram_size_select,
    output logic [15:0] boot_addr,
    output logic boot_busy,
    output logic [15:0] pc,
    output logic [7:0] psw,
    output logic [15:0] sp,
    output logic [15:0] bank_base
);
    localparam logic [7:0] PSW_RESET = 8'h02;
    localparam logic [15:0] SP_RESET = 16'h0000;

    // reset release synchroniser
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_n = rst_s2_q;

    // size selection settings
    logic [7:0] mss_q;
    logic [7:0] xss_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mss_q <= MSS_RESET; // R2
            xss_q <= XSS_RESET; // R2
        end else if (size_wr) begin
            mss_q <= memory_size_select_wd; // R3 R4
            xss_q <= expansion_ram_size_select_wd;
        end
    end

    // program memory limit follows the size setting
    wire logic rom48 = (mss_q == MSS_48K);
    wire logic [15:0] rom_last = rom48 ? ROM48_LAST : ROM60_LAST; // R5 R6
    wire logic xram_on = (xss_q == XSS_1536) || (xss_q == XSS_RESET);

    // raw range decode over the 16-bit space
    wire logic in_rom = (addr <= rom_last); // R1 R5 R6
    wire logic in_xram = xram_on && (addr >= XRAM_BASE) && (addr <= XRAM_LAST); // R15
    wire logic in_lcd = (addr >= LCD_BASE) && (addr <= LCD_LAST40); // R17
    wire logic in_hsram = (addr >= HSRAM_BASE) && (addr <= HSRAM_LAST); // R12
    wire logic in_peri = (addr >= PERI_BASE); // R20
    wire logic hs_fetch = in_hsram && is_fetch; // R14

    // display portion end: mask parts by variant, flash by pin groups
    wire logic [1:0] seg_groups = {1'b0, lcd_segment_out_hi} + {1'b0, lcd_segment_out_lo};
    wire logic [1:0] lcd_code = IS_FLASH ? seg_groups : lcd_variant; // R18 R19
    wire logic [15:0] lcd_last = (lcd_code == LCD_SEL24) ? LCD_LAST24 :
                                 (lcd_code == LCD_SEL32) ? LCD_LAST32 : LCD_LAST40;

    // one-hot selects, fetch from high-speed ram gets none
    region_s sel_d;
    assign sel_d.rom = in_rom; // R24
    assign sel_d.xram = in_xram && !in_rom; // R16 R24
    assign sel_d.lcd = in_lcd && !in_rom;
    assign sel_d.hsram = in_hsram && !in_rom && !hs_fetch; // R14 R24
    assign sel_d.peri = in_peri && !in_rom;

    // area attributes
    attr_s attr_d;
    assign attr_d.vector_area = sel_d.rom && (addr <= VEC_LAST); // R7
    assign attr_d.short_table_call_area = sel_d.rom && (addr >= SHORT_TABLE_CALL_BASE) && (addr <= SHORT_TABLE_CALL_LAST); // R10
    assign attr_d.fixed_area_call_area = sel_d.rom && (addr >= FIXED_AREA_CALL_BASE) && (addr <= FIXED_AREA_CALL_LAST); // R11
    assign attr_d.bank_area = sel_d.hsram && (addr >= BANK_BASE); // R13
    assign attr_d.lcd_display = sel_d.lcd && (addr <= lcd_last); // R17 R18 R19
    assign attr_d.fetch_fault = hs_fetch && !in_rom; // R14
    assign attr_d.unmapped = !(|sel_d) && !attr_d.fetch_fault;

    // offset within the selected region
    wire logic [15:0] base_d = sel_d.xram ? XRAM_BASE :
                               sel_d.lcd ? LCD_BASE :
                               sel_d.hsram ? HSRAM_BASE :
                               sel_d.peri ? PERI_BASE : ROM_BASE;
    wire logic [15:0] loc_d = addr - base_d;

    // vector slot index: one slot per 16-bit word, low byte even
    wire logic [15:0] vec_word = addr >> 1; // R8 R9
    wire logic [4:0] vidx_d = vec_word[4:0];

    // registered decode outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= '0;
            attr <= '0;
            local_addr <= 16'h0000;
            vector_index <= 5'h00;
        end else begin
            sel <= sel_d;
            attr <= attr_d;
            local_addr <= loc_d;
            vector_index <= vidx_d;
        end
    end

    // size settings shown straight from their flops
    assign memory_size_select = mss_q;
    assign expansion_ram_size_select = xss_q;

    // reset vector fetch: low byte from 0000H, high from 0001H
    boot_e boot_q;
    boot_e boot_d;
    logic [7:0] vec_lo_q;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    always_comb begin
        boot_d = boot_q;
        pc_d = pc_q;
        case (boot_q)
            BOOT_LO: begin
                boot_d = BOOT_HI;
            end
            BOOT_HI: begin
                boot_d = RUN;
                pc_d = {rd_byte, vec_lo_q}; // R23 R8
            end
            RUN: begin
                if (pc_load) begin
                    pc_d = pc_load_val;
                end
            end
            default: begin
                boot_d = BOOT_LO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_q <= BOOT_LO;
            vec_lo_q <= 8'h00;
            pc_q <= VEC_RESET;
        end else begin
            boot_q <= boot_d;
            pc_q <= pc_d; // R22 R23
            if (boot_q == BOOT_LO) begin
                vec_lo_q <= rd_byte;
            end
        end
    end

    // fetch address for the vector bytes, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_addr <= VEC_RESET; // R23
            boot_busy <= 1'b1;
        end else begin
            boot_addr <= VEC_RESET + 16'h0001;
            boot_busy <= (boot_d != RUN);
        end
    end
    assign pc = pc_q;

    // status word and stack pointer
    logic [7:0] psw_q;
    logic [15:0] sp_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psw_q <= PSW_RESET;
            sp_q <= SP_RESET;
        end else begin
            if (psw_wr) begin
                psw_q <= psw_wd; // R22
            end
            if (sp_wr) begin
                sp_q <= sp_wd; // R22
            end
        end
    end
    assign psw = psw_q;
    assign sp = sp_q;

    // base address of the selected register bank, bank 0 at the top
    logic [15:0] bank_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_q <= HSRAM_LAST - 16'h0007;
        end else begin
            bank_q <= BANK_BASE + ({14'h0000, ~bank_sel} << BANK_IDX_W); // R13
        end
    end
    assign bank_base = bank_q;
endmodule
